// ### rtl/srs_pkg.sv
// Constants for the status reporting and service request block.
// Assumes one instrument clock; shared by design and bench.
package srs_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int GROUP_WIDTH = 16;
    localparam int STD_WIDTH   = 8;
    localparam int QUEUE_WIDTH = 8;
    localparam int QUEUE_DEPTH = 16;

    // ------------------------------------------------------------
    // Operation group bits
    // ------------------------------------------------------------
    localparam int OP_CAL_DONE_BIT         = 0;
    localparam int OP_TRANSIENT_DONE_BIT   = 3;
    localparam int OP_MEASUREMENT_DONE_BIT = 4;

    // ------------------------------------------------------------
    // Fault group bits
    // ------------------------------------------------------------
    localparam int FLT_OUTPUT_VOLTAGE_FAULT_BIT   = 0;
    localparam int FLT_OVERCURRENT_TRIPPED_BIT    = 1;
    localparam int FLT_OVERTEMPERATURE_BIT        = 3;
    localparam int FLT_REMOTE_SHUTDOWN_ACTIVE_BIT = 9;
    localparam int FLT_RMS_LIMIT_ACTIVE_BIT       = 12;

    // ------------------------------------------------------------
    // Interface event bits
    // ------------------------------------------------------------
    localparam int STD_OP_COMPLETE_BIT = 0;
    localparam int STD_QUERY_ERR_BIT   = 2;
    localparam int STD_DEVICE_ERR_BIT  = 3;
    localparam int STD_EXEC_ERR_BIT    = 4;
    localparam int STD_CMD_ERR_BIT     = 5;
    localparam int STD_POWER_ON_BIT    = 7;

    // ------------------------------------------------------------
    // Summary byte bits
    // ------------------------------------------------------------
    localparam int STB_FAULT_SUMMARY_BIT     = 3;
    localparam int STB_MSG_AVAIL_BIT         = 4;
    localparam int STB_EVENT_SUMMARY_BIT     = 5;
    localparam int STB_SERVICE_BIT           = 6;
    localparam int STB_OPERATION_SUMMARY_BIT = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] GROUP_RESET = 16'h0000;
    localparam logic [7:0]  STD_RESET   = 8'h00;

    // ------------------------------------------------------------
    // Register selects of the access port
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SEL_OPERATION_SUMMARY_LIVE   = 4'h0,
        SEL_OPERATION_SUMMARY_EVENTS = 4'h1,
        SEL_OPERATION_SUMMARY_MASK   = 4'h2,
        SEL_FLT_LIVE    = 4'h3,
        SEL_FLT_EVENTS  = 4'h4,
        SEL_FLT_MASK    = 4'h5,
        SEL_STD_EVENTS  = 4'h6,
        SEL_STD_MASK    = 4'h7,
        SEL_SUMMARY     = 4'h8,
        SEL_SRQ_MASK    = 4'h9,
        SEL_POLL        = 4'ha,
        SEL_QUEUE       = 4'hb
    } srs_sel_t;

endpackage : srs_pkg

// ### rtl/srs_status_core.sv
// Status groups, summary byte, service request and output queue.
// Assumes condition pins are asynchronous; event strobes, queue push
// and the access port come from logic on clk_sys.
// Summary of operation
// - Live condition registers mirror monitored circuit signals
// - Operation and fault event registers latch rises, clear on read
// - Enable masks select events into summaries
// - Enabled operation events form summary bit 7
// - Operation bits: calibration 0, transient 3, measurement 4
// - Fault bits 0,1,3,9,12 as assigned
// - Enabled fault events form summary bit 3
// - Interface event bits 0,2,3,4,5,7 assigned
// - Interface event read returns and clears
// - Interface mask gates like other masks
// - Power-on sets power-on event bit
// - Summary query returns master summary, changes nothing
// - Serial poll returns request bit, clears it
// - Master summary is unlatched masked OR
// - Service request drives line, latches bit 6
// - Poll clear leaves other summary bits alone
// - Response bytes wait in a FIFO queue
// - Message available bit 4 while queue nonempty
// - Bit 5 is enabled interface event summary
// - Power-up clears all groups and masks
// - Event read clears, summary drops with it
`timescale 1ns/1ps
`default_nettype none

module srs_status_core
    import srs_pkg::*;
#(
    parameter int QDEPTH = QUEUE_DEPTH
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    input  wire logic                   calDone,
    input  wire logic                   transientDone,
    input  wire logic                   measurementDone,
    input  wire logic                   outputVoltageFault,
    input  wire logic                   overcurrentTripped,
    input  wire logic                   overtemperature,
    input  wire logic                   remoteShutdownActive,
    input  wire logic                   rmsLimitActive,
    input  wire logic                   opcEvent,
    input  wire logic                   queryErrEvent,
    input  wire logic                   deviceErrEvent,
    input  wire logic                   execErrEvent,
    input  wire logic                   cmdErrEvent,
    input  wire logic                   accValid,
    input  wire srs_sel_t               accSel,
    input  wire logic                   accWrite,
    input  wire logic [GROUP_WIDTH-1:0] accWdata,
    output logic                        rdValid,
    output logic      [GROUP_WIDTH-1:0] rdData,
    input  wire logic                   qPushValid,
    input  wire logic [QUEUE_WIDTH-1:0] qPushData,
    output logic                        qPushReady,
    output logic                        srq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    localparam int PW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;

    if (QDEPTH < 2 || (1 << PW) != QDEPTH) begin : g_bad_depth
        $error("QDEPTH must be a power of two, at least 2");
    end

    // ------------------------------------------------------------
    // Condition pin synchronisers
    // ------------------------------------------------------------
    localparam int NCOND = 8;

    logic [NCOND-1:0] condRaw;
    logic [NCOND-1:0] condMeta;
    logic [NCOND-1:0] condSync;
    logic [NCOND-1:0] condPrev;

    assign condRaw = {rmsLimitActive, remoteShutdownActive, overtemperature,
                      overcurrentTripped, outputVoltageFault,
                      measurementDone, transientDone, calDone};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            condMeta <= '0;
            condSync <= '0;
            condPrev <= '0;
        end else if (ce) begin
            condMeta <= condRaw;
            condSync <= condMeta;
            condPrev <= condSync;
        end
    end

    // ------------------------------------------------------------
    // Live state vectors and rising edges
    // ------------------------------------------------------------
    logic [GROUP_WIDTH-1:0] opLive;
    logic [GROUP_WIDTH-1:0] fltLive;
    logic [GROUP_WIDTH-1:0] opPrev;
    logic [GROUP_WIDTH-1:0] fltPrev;
    logic [GROUP_WIDTH-1:0] opRise;
    logic [GROUP_WIDTH-1:0] fltRise;

    function automatic logic [31:0] place(input logic [NCOND-1:0] c);
        logic [GROUP_WIDTH-1:0] op;
        logic [GROUP_WIDTH-1:0] fl;
        op = GROUP_RESET;
        fl = GROUP_RESET;
        op[OP_CAL_DONE_BIT]                = c[0];
        op[OP_TRANSIENT_DONE_BIT]          = c[1];
        op[OP_MEASUREMENT_DONE_BIT]        = c[2];
        fl[FLT_OUTPUT_VOLTAGE_FAULT_BIT]   = c[3];
        fl[FLT_OVERCURRENT_TRIPPED_BIT]    = c[4];
        fl[FLT_OVERTEMPERATURE_BIT]        = c[5];
        fl[FLT_REMOTE_SHUTDOWN_ACTIVE_BIT] = c[6];
        fl[FLT_RMS_LIMIT_ACTIVE_BIT]       = c[7];
        return {fl, op};
    endfunction : place

    assign {fltLive, opLive} = place(condSync);
    assign {fltPrev, opPrev} = place(condPrev);
    assign opRise  = opLive & ~opPrev;
    assign fltRise = fltLive & ~fltPrev;

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic rdReq;
    logic wrReq;

    assign rdReq = ce && accValid && !accWrite;
    assign wrReq = ce && accValid && accWrite;

    // ------------------------------------------------------------
    // Output queue
    // ------------------------------------------------------------
    logic [QUEUE_WIDTH-1:0] qMem [QDEPTH];
    logic [PW-1:0]          qWrPtr;
    logic [PW-1:0]          qRdPtr;
    logic [PW:0]            qCount;
    logic                   qPush;
    logic                   qPop;
    logic                   qUnderflow;
    logic                   msgAvail;

    assign qPushReady = (qCount != (PW+1)'(QDEPTH));
    assign qPush      = ce && qPushValid && qPushReady;
    assign qPop       = rdReq && accSel == SEL_QUEUE && qCount != '0;
    assign qUnderflow = rdReq && accSel == SEL_QUEUE && qCount == '0;
    assign msgAvail   = (qCount != '0);

    always_ff @(posedge clk_sys) begin
        if (qPush) begin
            qMem[qWrPtr] <= qPushData;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            qWrPtr <= '0;
            qRdPtr <= '0;
            qCount <= '0;
        end else begin
            qWrPtr <= qWrPtr + PW'(qPush);
            qRdPtr <= qRdPtr + PW'(qPop);
            qCount <= qCount + (PW+1)'(qPush) - (PW+1)'(qPop);
        end
    end

    // ------------------------------------------------------------
    // Event registers, set wins over read clear
    // ------------------------------------------------------------
    logic [GROUP_WIDTH-1:0] opEvents;
    logic [GROUP_WIDTH-1:0] fltEvents;
    logic [STD_WIDTH-1:0]   stdEvents;
    logic [STD_WIDTH-1:0]   stdSet;
    logic                   ponPending;

    always_comb begin
        stdSet = STD_RESET;
        stdSet[STD_OP_COMPLETE_BIT] = opcEvent;
        stdSet[STD_QUERY_ERR_BIT]   = queryErrEvent | qUnderflow;
        stdSet[STD_DEVICE_ERR_BIT]  = deviceErrEvent;
        stdSet[STD_EXEC_ERR_BIT]    = execErrEvent;
        stdSet[STD_CMD_ERR_BIT]     = cmdErrEvent;
        stdSet[STD_POWER_ON_BIT]    = ponPending;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ponPending <= 1'b1;
        end else if (ce) begin
            ponPending <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            opEvents  <= GROUP_RESET;
            fltEvents <= GROUP_RESET;
            stdEvents <= STD_RESET;
        end else if (ce) begin
            opEvents  <= ((rdReq && accSel == SEL_OPERATION_SUMMARY_EVENTS) ?
                          GROUP_RESET : opEvents) | opRise;
            fltEvents <= ((rdReq && accSel == SEL_FLT_EVENTS) ?
                          GROUP_RESET : fltEvents) | fltRise;
            stdEvents <= ((rdReq && accSel == SEL_STD_EVENTS) ?
                          STD_RESET : stdEvents) | stdSet;
        end
    end

    // ------------------------------------------------------------
    // Enable masks
    // ------------------------------------------------------------
    logic [GROUP_WIDTH-1:0] opMask;
    logic [GROUP_WIDTH-1:0] fltMask;
    logic [STD_WIDTH-1:0]   stdMask;
    logic [STD_WIDTH-1:0]   srqMask;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            opMask  <= GROUP_RESET;
            fltMask <= GROUP_RESET;
            stdMask <= STD_RESET;
            srqMask <= STD_RESET;
        end else if (wrReq) begin
            unique case (accSel)
                SEL_OPERATION_SUMMARY_MASK: opMask  <= accWdata;
                SEL_FLT_MASK:  fltMask <= accWdata;
                SEL_STD_MASK:  stdMask <= accWdata[STD_WIDTH-1:0];
                SEL_SRQ_MASK:  srqMask <= accWdata[STD_WIDTH-1:0];
                default:       ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Summary byte and master summary
    // ------------------------------------------------------------
    logic                 opSum;
    logic                 fltSum;
    logic                 stdSum;
    logic                 mss;
    logic                 mssPrev;
    logic                 rqs;
    logic                 mssRise;
    logic                 pollReq;
    logic [STD_WIDTH-1:0] stbBase;

    assign opSum  = |(opEvents & opMask);
    assign fltSum = |(fltEvents & fltMask);
    assign stdSum = |(stdEvents & stdMask);

    always_comb begin
        stbBase = STD_RESET;
        stbBase[STB_FAULT_SUMMARY_BIT]     = fltSum;
        stbBase[STB_MSG_AVAIL_BIT]         = msgAvail;
        stbBase[STB_EVENT_SUMMARY_BIT]     = stdSum;
        stbBase[STB_OPERATION_SUMMARY_BIT] = opSum;
    end

    assign mss     = |(stbBase & srqMask);
    assign mssRise = mss && !mssPrev;
    assign pollReq = rdReq && accSel == SEL_POLL;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mssPrev <= 1'b0;
            rqs     <= 1'b0;
        end else if (ce) begin
            mssPrev <= mss;
            if (mssRise) begin
                rqs <= 1'b1;
            end else if (pollReq) begin
                rqs <= 1'b0;
            end
        end
    end

    assign srq = rqs;

    // ------------------------------------------------------------
    // Read answer, one cycle after the request
    // ------------------------------------------------------------
    logic [GROUP_WIDTH-1:0] next_rdData;

    always_comb begin
        next_rdData = GROUP_RESET;
        unique case (accSel)
            SEL_OPERATION_SUMMARY_LIVE:   next_rdData = opLive;
            SEL_OPERATION_SUMMARY_EVENTS: next_rdData = opEvents;
            SEL_OPERATION_SUMMARY_MASK:   next_rdData = opMask;
            SEL_FLT_LIVE:    next_rdData = fltLive;
            SEL_FLT_EVENTS:  next_rdData = fltEvents;
            SEL_FLT_MASK:    next_rdData = fltMask;
            SEL_STD_EVENTS:  next_rdData[STD_WIDTH-1:0] = stdEvents;
            SEL_STD_MASK:    next_rdData[STD_WIDTH-1:0] = stdMask;
            SEL_SUMMARY:     next_rdData[STD_WIDTH-1:0] =
                stbBase | (STD_WIDTH'(mss) << STB_SERVICE_BIT);
            SEL_SRQ_MASK:    next_rdData[STD_WIDTH-1:0] = srqMask;
            SEL_POLL:        next_rdData[STD_WIDTH-1:0] =
                stbBase | (STD_WIDTH'(rqs) << STB_SERVICE_BIT);
            SEL_QUEUE:       next_rdData[QUEUE_WIDTH-1:0] =
                msgAvail ? qMem[qRdPtr] : '0;
            default:         next_rdData = GROUP_RESET;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdValid <= 1'b0;
            rdData  <= GROUP_RESET;
        end else if (ce) begin
            rdValid <= rdReq;
            rdData  <= rdReq ? next_rdData : rdData;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_event_keeps_rise: assert property (
        (ce && opRise != '0) |=> (opEvents & $past(opRise)) == $past(opRise)
    ) else $error("Operation event rise lost");
    chk_read_clears: assert property (
        (rdReq && accSel == SEL_FLT_EVENTS && fltRise == '0)
            |=> rdValid && fltEvents == '0
    ) else $error("Fault events not cleared by read");
    chk_operation_summary_summary: assert property (
        (rdReq && accSel == SEL_SUMMARY)
            |=> rdValid && rdData[STB_OPERATION_SUMMARY_BIT] == $past(opSum)
    ) else $error("Operation summary bit wrong");
    chk_fault_summary: assert property (
        (rdReq && accSel == SEL_SUMMARY)
            |=> rdData[STB_FAULT_SUMMARY_BIT] == $past(fltSum)
    ) else $error("Fault summary bit wrong");
    chk_query_keeps_rqs: assert property (
        (rdReq && accSel == SEL_SUMMARY && !mssRise) |=> $stable(rqs)
    ) else $error("Summary query disturbed request bit");
    chk_poll_clears: assert property (
        (pollReq && !mssRise) |=> !srq && rdData[STB_SERVICE_BIT] == $past(rqs)
            && rdData[STB_MSG_AVAIL_BIT] == $past(msgAvail)
    ) else $error("Serial poll answer or clear wrong");
    chk_srq_raise: assert property (
        (ce && mss && !mssPrev) |=> srq [*1] ##0 rqs
    ) else $error("Service request not raised");
    chk_msg_avail: assert property (
        (qPush && !qPop) |=> (qCount != '0) && stbBase[STB_MSG_AVAIL_BIT]
    ) else $error("Message available not set");
    chk_power_on: assert property (
        (ce && ponPending) |=> stdEvents[STD_POWER_ON_BIT]
    ) else $error("Power-on bit not set");
    chk_mask_write: assert property (
        (wrReq && accSel == SEL_OPERATION_SUMMARY_MASK) |=> opMask == $past(accWdata)
    ) else $error("Operation mask not written");

endmodule : srs_status_core

`default_nettype wire

// ### tb/srs_bus_ctrl_model.sv
// Bus controller model: register queries, mask writes, serial polls.
// Assumes the bench calls its tasks; all requests change on falling edges.
`timescale 1ns/1ps
`default_nettype none

module srs_bus_ctrl_model
    import srs_pkg::*;
(
    input  wire logic                   clk_sys,
    output logic                        accValid,
    output srs_sel_t                    accSel,
    output logic                        accWrite,
    output logic      [GROUP_WIDTH-1:0] accWdata
);
    initial begin
        accValid = 1'b0;
        accSel   = SEL_SUMMARY;
        accWrite = 1'b0;
        accWdata = '0;
    end

    // One request per call, held for one cycle
    // Event reads clear them; mask writes gate summaries
    task automatic acc(input srs_sel_t sel, input logic wr,
                       input logic [GROUP_WIDTH-1:0] wd);
        @(negedge clk_sys);
        accValid = 1'b1;
        accSel   = sel;
        accWrite = wr;
        accWdata = wd;
    endtask : acc

    // Release: data no longer holds its last value
    task automatic idle();
        @(negedge clk_sys);
        accValid = 1'b0;
        accWdata = ~accWdata;
    endtask : idle

endmodule : srs_bus_ctrl_model

`default_nettype wire

// ### tb/srs_status_core_tb.sv
// Self-checking bench for the status reporting core.
// Assumes srs_pkg and srs_bus_ctrl_model; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none

module srs_status_core_tb
    import srs_pkg::*;
;
    logic                   clk_sys;
    logic                   rst_n;
    logic                   ce;
    logic             [2:0] opPins;
    logic             [4:0] fltPins;
    logic             [4:0] evPins;
    logic                   accValid;
    srs_sel_t               accSel;
    logic                   accWrite;
    logic [GROUP_WIDTH-1:0] accWdata;
    logic                   rdValid;
    logic [GROUP_WIDTH-1:0] rdData;
    logic                   qPushValid;
    logic [QUEUE_WIDTH-1:0] qPushData;
    logic                   qPushReady;
    logic                   srq;
    logic            [15:0] expQ[$];
    logic [QUEUE_WIDTH-1:0] bytesQ[$];
    int                     n_errors;
    int                     checks_done;

    srs_status_core #(.QDEPTH(4)) u_srs_status_core (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .calDone(opPins[0]), .transientDone(opPins[1]),
        .measurementDone(opPins[2]),
        .outputVoltageFault(fltPins[0]), .overcurrentTripped(fltPins[1]),
        .overtemperature(fltPins[2]), .remoteShutdownActive(fltPins[3]),
        .rmsLimitActive(fltPins[4]),
        .opcEvent(evPins[0]), .queryErrEvent(evPins[1]),
        .deviceErrEvent(evPins[2]), .execErrEvent(evPins[3]),
        .cmdErrEvent(evPins[4]),
        .accValid(accValid), .accSel(accSel), .accWrite(accWrite),
        .accWdata(accWdata), .rdValid(rdValid), .rdData(rdData),
        .qPushValid(qPushValid), .qPushData(qPushData),
        .qPushReady(qPushReady), .srq(srq));

    srs_bus_ctrl_model u_srs_bus_ctrl_model (
        .clk_sys(clk_sys), .accValid(accValid), .accSel(accSel),
        .accWrite(accWrite), .accWdata(accWdata));

    always #12.5 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // Oldest note against each read answer; stray answers never match
    always @(negedge clk_sys) begin
        if (rdValid === 1'b1) begin
            if (expQ.size() > 0) check(rdData, expQ.pop_front());
            else check(rdData, 'x);
        end
    end

    task automatic rd(input srs_sel_t sel, input logic [15:0] exp);
        expQ.push_back(exp);
        u_srs_bus_ctrl_model.acc(sel, 1'b0, '0);
    endtask : rd

    task automatic wr(input srs_sel_t sel, input logic [15:0] d);
        u_srs_bus_ctrl_model.acc(sel, 1'b1, d);
    endtask : wr

    task automatic gap(input int n);
        u_srs_bus_ctrl_model.idle();
        repeat (n) @(negedge clk_sys);
    endtask : gap

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        opPins = '0;
        fltPins = '0;
        evPins = '0;
        qPushValid = 1'b0;
        qPushData = '0;
        n_errors = 0;
        checks_done = 0;
        void'($urandom(4));
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        rd(SEL_STD_EVENTS, 16'h0080);
        rd(SEL_STD_EVENTS, 16'h0000);
        rd(SEL_OPERATION_SUMMARY_MASK, 16'h0000);
        rd(SEL_FLT_MASK, 16'h0000);
        rd(SEL_STD_MASK, 16'h0000);
        rd(SEL_SRQ_MASK, 16'h0000);
        rd(SEL_SUMMARY, 16'h0000);
        gap(1);
        opPins = 3'b111;
        fltPins = 5'b11111;
        gap(5);
        rd(SEL_OPERATION_SUMMARY_LIVE, 16'h0019);
        rd(SEL_OPERATION_SUMMARY_EVENTS, 16'h0019);
        rd(SEL_OPERATION_SUMMARY_EVENTS, 16'h0000);
        rd(SEL_FLT_LIVE, 16'h120b);
        rd(SEL_FLT_EVENTS, 16'h120b);
        rd(SEL_FLT_EVENTS, 16'h0000);
        gap(1);
        opPins = '0;
        fltPins = '0;
        gap(4);
        wr(SEL_OPERATION_SUMMARY_LIVE, 16'hffff);
        rd(SEL_OPERATION_SUMMARY_LIVE, 16'h0000);
        rd(SEL_FLT_EVENTS, 16'h0000);
        wr(SEL_FLT_MASK, 16'h000b);
        wr(SEL_SRQ_MASK, 16'h0008);
        rd(SEL_FLT_MASK, 16'h000b);
        rd(SEL_SRQ_MASK, 16'h0008);
        gap(1);
        fltPins = 5'b00010;
        gap(6);
        check(16'(srq), 16'h0001);
        rd(SEL_SUMMARY, 16'h0048);
        rd(SEL_SUMMARY, 16'h0048);
        rd(SEL_POLL, 16'h0048);
        rd(SEL_SUMMARY, 16'h0048);
        rd(SEL_POLL, 16'h0008);
        gap(2);
        check(16'(srq), 16'h0000);
        rd(SEL_FLT_EVENTS, 16'h0002);
        gap(1);
        rd(SEL_SUMMARY, 16'h0000);
        wr(SEL_OPERATION_SUMMARY_MASK, 16'h0010);
        gap(1);
        opPins = 3'b100;
        gap(5);
        rd(SEL_SUMMARY, 16'h0080);
        rd(SEL_OPERATION_SUMMARY_EVENTS, 16'h0010);
        gap(1);
        rd(SEL_SUMMARY, 16'h0000);
        gap(1);
        evPins = 5'b11111;
        @(negedge clk_sys);
        evPins = '0;
        gap(2);
        rd(SEL_STD_EVENTS, 16'h003d);
        wr(SEL_STD_MASK, 16'h0020);
        gap(1);
        evPins = 5'b10000;
        @(negedge clk_sys);
        evPins = '0;
        gap(2);
        rd(SEL_SUMMARY, 16'h0020);
        rd(SEL_STD_EVENTS, 16'h0020);
        gap(1);
        rd(SEL_SUMMARY, 16'h0000);
        gap(1);
        for (int i = 0; i < 5; i++) begin
            @(negedge clk_sys);
            qPushValid = 1'b1;
            qPushData = QUEUE_WIDTH'($urandom);
            if (i < 4) bytesQ.push_back(qPushData);
        end
        @(negedge clk_sys);
        qPushValid = 1'b0;
        check(16'(qPushReady), 16'h0000);
        rd(SEL_SUMMARY, 16'h0010);
        for (int i = 0; i < 4; i++) begin
            rd(SEL_QUEUE, 16'(bytesQ.pop_front()));
        end
        gap(1);
        rd(SEL_SUMMARY, 16'h0000);
        rd(SEL_QUEUE, 16'h0000);
        gap(2);
        ce = 1'b0;
        evPins = 5'b10000;
        @(negedge clk_sys);
        evPins = '0;
        ce = 1'b1;
        rd(SEL_STD_EVENTS, 16'h0004);
        gap(4);
        rst_n = 1'b0;
        @(negedge clk_sys);
        rst_n = 1'b1;
        check(16'(srq), 16'h0000);
        rd(SEL_STD_EVENTS, 16'h0080);
        rd(SEL_SRQ_MASK, 16'h0000);
        gap(3);
        rd(SEL_FLT_EVENTS, 16'h0002);
        rd(SEL_SUMMARY, 16'h0000);
        gap(2);
        check(16'(expQ.size()), 16'h0000);
        finish_test();
    end

    initial begin
        #100000;
        n_errors++;
        finish_test();
    end

endmodule : srs_status_core_tb

`default_nettype wire
